// File: logic/tick_timer_pkg.sv
/*
 Package for the time base tick timer: register map, field layout,
 reset values and divider chain widths.
 Assumes a 20 MHz system clock and an 8-bit-register view mapped onto
 32-bit Avalon-MM words.
*/
package tick_timer_pkg;
    // Printed offset 0x0039 is not a multiple of four: it is an index
    localparam logic [7:0] TICK_CONTROL_INDEX = 8'h39;
    localparam logic [7:0] IRQ_STATUS_INDEX = 8'h3a;
    localparam logic [7:0] IRQ_MASK_INDEX = 8'h3b;
    localparam logic [7:0] MODE_CONTROL_INDEX = 8'h3c;
    localparam int ADDR_WIDTH = 10;
    localparam int ENABLE_BIT = 3;
    localparam int RATE_LSB = 0;
    localparam int RATE_WIDTH = 3;
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    // Mode control bits
    localparam int MODE_SLOW_BIT = 0;
    localparam int MODE_PRESCALE_BIT = 1;
    localparam int MODE_STOP_BIT = 2;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam int DIV_WIDTH = 22;
    // Low-frequency clock emulated as gear clock / LOW_CLOCK_DIV
    localparam int LOW_CLOCK_DIV = 610;
    localparam int LOW_DIV_WIDTH = 16;
    localparam int LOW_CHAIN_WIDTH = 15;
    localparam int CLOCK_MHZ = 20;
    localparam int CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;
endpackage

// File: logic/edge_pulse.sv
/*
 Falling edge detector on a divider tap, one clock pulse per edge.
 Assumes the tap is already synchronous to clock.
*/
`timescale 1ns/1ps
module edge_pulse
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic level,
    output logic fall
);
    logic last;
    logic next_last;

    always_comb
    begin
        next_last = level;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            last <= 1'b0;
        end
        else
        begin
            last <= next_last;
        end
    end

    assign fall = last & ~level;
endmodule // edge_pulse

// File: logic/tick_timer.sv
/*
 Time base tick timer with free-running divider chains, tap select,
 interrupt enable and an Avalon-MM register slave with waitrequest.
 Assumes the interrupt controller takes a one-cycle request pulse and
 that software keeps reserved rate codes out of the control register.
*/
`timescale 1ns/1ps
//
// Function
// - Enabled, every falling edge of selected tap issues one tick request.
// - Disabled, no tick requests are issued at any rate.
// - STOP entry clears enable and keeps rate select.
// - Divider chains run continuously regardless of enable.
// - First request at next tap falling edge, interval may be short.
// - Control register bits 7 to 4 read as zero.
// - Prescaled low clock in fast modes gives requests at exact low chain periods, without jitter.
// - Mode switches may give off-period requests as the tap moves between chains.
// - Fast mode taps are gear clock over 2^22,20,15,13,12,11,10,8.
// - Control at 0x39: enable bit 3, rate bits 2..0, reset 0.
module tick_timer
    import tick_timer_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic tick_interrupt_request,
    output logic irq
);
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_e;

    bus_state_e bus_state;
    bus_state_e next_bus_state;
    logic tick_irq_enable;
    logic next_tick_irq_enable;
    logic [RATE_WIDTH-1:0] tick_rate_select;
    logic [RATE_WIDTH-1:0] next_tick_rate_select;
    logic [2:0] system_control_one;
    logic [2:0] next_system_control_one;
    logic irq_status;
    logic next_irq_status;
    logic irq_mask;
    logic next_irq_mask;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic next_tick_request;
    logic next_irq;
    logic [DIV_WIDTH-1:0] gear_chain;
    logic [DIV_WIDTH-1:0] next_gear_chain;
    logic [LOW_DIV_WIDTH-1:0] low_div;
    logic [LOW_DIV_WIDTH-1:0] next_low_div;
    logic [LOW_CHAIN_WIDTH-1:0] low_chain;
    logic [LOW_CHAIN_WIDTH-1:0] next_low_chain;
    logic tap;
    logic tap_fall;
    logic slow_mode;
    logic prescale;
    logic access;
    logic [7:0] word_index;
    logic write_control;
    logic stop_entry;

    assign slow_mode = system_control_one[MODE_SLOW_BIT];
    assign prescale = system_control_one[MODE_PRESCALE_BIT];
    assign access = (read | write) & (bus_state == BUS_IDLE);
    assign word_index = address[9:2];
    assign write_control = access & write & byteenable[0] & (word_index == TICK_CONTROL_INDEX);
    assign stop_entry = access & write & byteenable[0] & (word_index == MODE_CONTROL_INDEX)
        & writedata[MODE_STOP_BIT];

    // Chains never stop, so the first enabled interval is short
    always_comb
    begin
        next_gear_chain = gear_chain + 1'b1;
        next_low_div = low_div + 1'b1;
        next_low_chain = low_chain;
        if (low_div == LOW_DIV_WIDTH'(LOW_CLOCK_DIV - 1))
        begin
            next_low_div = '0;
            next_low_chain = low_chain + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            gear_chain <= '0;
            low_div <= '0;
            low_chain <= '0;
        end
        else
        begin
            gear_chain <= next_gear_chain;
            low_div <= next_low_div;
            low_chain <= next_low_chain;
        end
    end

    // Low clock is derived in this domain, so mode switches only move the tap
    always_comb
    begin
        tap = 1'b0;
        if (slow_mode || prescale)
        begin
            case (tick_rate_select)
                3'h0: tap = low_chain[14];
                3'h1: tap = low_chain[12];
                3'h2: tap = low_chain[7];
                3'h3: tap = low_chain[5];
                3'h4: tap = low_chain[4];
                3'h5: tap = low_chain[3];
                3'h6: tap = low_chain[2];
                default: tap = 1'b0; // Reserved code gives no edges
            endcase
        end
        else
        begin
            case (tick_rate_select)
                3'h0: tap = gear_chain[21];
                3'h1: tap = gear_chain[19];
                3'h2: tap = gear_chain[14];
                3'h3: tap = gear_chain[12];
                3'h4: tap = gear_chain[11];
                3'h5: tap = gear_chain[10];
                3'h6: tap = gear_chain[9];
                default: tap = gear_chain[7];
            endcase
        end
    end

    edge_pulse tap_edge
    (
        .clock(clock),
        .reset_n(reset_n),
        .level(tap),
        .fall(tap_fall)
    );

    always_comb
    begin
        next_tick_irq_enable = tick_irq_enable;
        next_tick_rate_select = tick_rate_select;
        next_system_control_one = system_control_one;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_readdata = readdata;
        next_waitrequest = 1'b1;
        next_bus_state = BUS_IDLE;
        // Rate change while enabled is allowed but may misplace a tick
        if (write_control)
        begin
            next_tick_irq_enable = writedata[ENABLE_BIT];
            next_tick_rate_select = writedata[RATE_LSB +: RATE_WIDTH];
        end
        if (access & write & byteenable[0] & (word_index == MODE_CONTROL_INDEX))
        begin
            next_system_control_one = {1'b0, writedata[MODE_PRESCALE_BIT],
                writedata[MODE_SLOW_BIT]};
        end
        if (access & write & byteenable[0] & (word_index == IRQ_MASK_INDEX))
        begin
            next_irq_mask = writedata[0];
        end
        if (stop_entry)
        begin
            next_tick_irq_enable = 1'b0;
        end
        if (access & read)
        begin
            case (word_index)
                TICK_CONTROL_INDEX: next_readdata = {28'h0000000, tick_irq_enable,
                    tick_rate_select};
                IRQ_STATUS_INDEX: next_readdata = {31'h00000000, irq_status};
                IRQ_MASK_INDEX: next_readdata = {31'h00000000, irq_mask};
                MODE_CONTROL_INDEX: next_readdata = {30'h00000000, system_control_one[1:0]};
                default: next_readdata = 32'h00000000;
            endcase
            if (word_index == IRQ_STATUS_INDEX)
            begin
                next_irq_status = 1'b0;
            end
        end
        // Set wins over read clear
        if (next_tick_request)
        begin
            next_irq_status = 1'b1;
        end
        case (bus_state)
            BUS_IDLE:
            begin
                if (read | write)
                begin
                    next_waitrequest = 1'b0;
                    next_bus_state = BUS_DONE;
                end
            end
            BUS_DONE:
            begin
                next_bus_state = BUS_IDLE;
            end
            default:
            begin
                next_bus_state = BUS_IDLE;
            end
        endcase
        next_irq = next_irq_status & next_irq_mask;
    end

    // Request follows the tap edge only while enabled
    assign next_tick_request = tap_fall & tick_irq_enable;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            bus_state <= BUS_IDLE;
            tick_irq_enable <= CONTROL_RESET[ENABLE_BIT];
            tick_rate_select <= CONTROL_RESET[RATE_WIDTH-1:0];
            system_control_one <= MODE_RESET;
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
            readdata <= 32'h00000000;
            waitrequest <= 1'b1;
            tick_interrupt_request <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            bus_state <= next_bus_state;
            tick_irq_enable <= next_tick_irq_enable;
            tick_rate_select <= next_tick_rate_select;
            system_control_one <= next_system_control_one;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            readdata <= next_readdata;
            waitrequest <= next_waitrequest;
            tick_interrupt_request <= next_tick_request;
            irq <= next_irq;
        end
    end
endmodule // tick_timer

// File: test/tick_timer_properties.sv
/* Port checker for the tick timer.
 Bound from the bench top file; sees only the top-level ports. */
`timescale 1ns/1ps
module tick_timer_properties
    import tick_timer_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic tick_interrupt_request,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    pulse_single_a: assert property (tick_interrupt_request |=> !tick_interrupt_request)
        else $error("tick request longer than one cycle");
    // Fastest tap is 256 cycles, so eight quiet cycles is safe
    tick_gap_a: assert property (tick_interrupt_request |=> !tick_interrupt_request [*8])
        else $error("tick requests too close");
    answer_next_a: assert property ($rose(read || write) |=> !waitrequest)
        else $error("no answer one cycle after request");
    wait_single_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    wait_cause_a: assert property (!waitrequest |-> $past(read || write))
        else $error("answer without request");
    upper_zero_a: assert property (read && !waitrequest
        && address == {TICK_CONTROL_INDEX, 2'b00} |-> readdata[31:4] == 28'h0)
        else $error("control upper bits not zero");
    data_hold_a: assert property (!$stable(readdata) |-> $past(read))
        else $error("read data changed without read");
    // Status and request register on the same edge, so a tick raises both at once
    irq_cause_a: assert property ($rose(irq) |-> tick_interrupt_request
        || $past(tick_interrupt_request) || $past(tick_interrupt_request, 2)
        || $past(tick_interrupt_request, 3)
        || $past(write) || $past(write, 2) || $past(write, 3))
        else $error("irq rose without cause");
endmodule // tick_timer_properties

// File: test/irq_ctrl_model.sv
/* Interrupt controller model: counts tick request pulses.
 Assumes each pulse is one clock wide and synchronous to clock. */
`timescale 1ns/1ps
module irq_ctrl_model
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tick_interrupt_request,
    output int tick_count
);
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            tick_count <= 0;
        else if (tick_interrupt_request)
            tick_count <= tick_count + 1;
    end
endmodule // irq_ctrl_model

// File: test/tick_timer_tb.sv
/* Self-checking bench for the tick timer.
 Drives Avalon-MM accesses, models control and rate periods. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tick_timer_tb;
    import tick_timer_pkg::*;
    logic clock, reset_n, read, write, waitrequest, tick_interrupt_request, irq;
    logic [ADDR_WIDTH-1:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    int checks = 0, miscompares = 0, tick_count, cyc = 0, seed = 32'h103a557c;
    int ctl, t0, t1, te, k;
    int sh[8] = '{22, 20, 15, 13, 12, 11, 10, 8};
    tick_timer u_tick_timer(.clock(clock), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .tick_interrupt_request(tick_interrupt_request), .irq(irq));
    irq_ctrl_model u_irq_ctrl_model(.clock(clock), .reset_n(reset_n),
        .tick_interrupt_request(tick_interrupt_request), .tick_count(tick_count));
    initial
    begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    task end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task acc(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= wd;
        do begin @(posedge clock); n++; end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20)
        begin
            miscompares++;
            end_sim();
        end
    endtask
    task rdchk(input logic [7:0] idx, input int e, input string n);
        acc(1'b0, idx, 32'h0);
        `CHK(n, e[31:0], rd)
    endtask
    task wtick(output int t);
        int n;
        n = 0;
        do begin @(posedge clock); n++; end while (tick_interrupt_request !== 1'b1 && n < 5000);
        if (n >= 5000)
        begin
            miscompares++;
            end_sim();
        end
        t = cyc;
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        miscompares++;
        end_sim();
    end
    initial
    begin
        {reset_n, read, write, address, writedata} = '0;
        byteenable = 4'hf;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        rdchk(TICK_CONTROL_INDEX, 0, "control reset");
        rdchk(8'h10, 0, "unmapped");
        for (k = 4; k < 8; k++)
        begin
            acc(1'b1, TICK_CONTROL_INDEX, k);
            acc(1'b1, TICK_CONTROL_INDEX, 8 | k);
            te = cyc;
            wtick(t0);
            `CHK("first gap", 1'b1, (t0 - te) <= (1 << sh[k]))
            wtick(t1);
            `CHK("period", 32'(1 << sh[k]), 32'(t1 - t0))
            acc(1'b1, TICK_CONTROL_INDEX, k);
        end
        $display("rates done");
        repeat (300) @(posedge clock);
        ctl = 8'hff & 8'h0f;
        acc(1'b1, TICK_CONTROL_INDEX, {$random(seed)} | 32'hff);
        rdchk(TICK_CONTROL_INDEX, ctl, "control");
        wtick(t0);
        `CHK("phase", 0, (t0 - t1) % 256)
        $display("phase done");
        acc(1'b1, IRQ_MASK_INDEX, 1);
        wtick(t0);
        repeat (3) @(posedge clock);
        `CHK("irq", 1'b1, irq)
        rdchk(IRQ_STATUS_INDEX, 1, "status");
        repeat (3) @(posedge clock);
        `CHK("irq clear", 1'b0, irq)
        acc(1'b1, IRQ_MASK_INDEX, 0);
        wtick(t0);
        repeat (3) @(posedge clock);
        `CHK("irq masked", 1'b0, irq)
        rdchk(IRQ_STATUS_INDEX, 1, "status masked");
        $display("irq done");
        acc(1'b1, TICK_CONTROL_INDEX, 7);
        k = tick_count;
        repeat (600) @(posedge clock);
        `CHK("no ticks", k, tick_count)
        acc(1'b1, MODE_CONTROL_INDEX, 2);
        rdchk(MODE_CONTROL_INDEX, 2, "mode prescale");
        acc(1'b1, TICK_CONTROL_INDEX, 8'h0e);
        wtick(t0);
        wtick(t1);
        `CHK("low period", 32'(LOW_CLOCK_DIV * 8), 32'(t1 - t0))
        acc(1'b1, TICK_CONTROL_INDEX, 6);
        acc(1'b1, MODE_CONTROL_INDEX, 0);
        $display("low clock done");
        acc(1'b1, TICK_CONTROL_INDEX, 5);
        acc(1'b1, TICK_CONTROL_INDEX, 8'h0d);
        acc(1'b1, MODE_CONTROL_INDEX, 4);
        rdchk(TICK_CONTROL_INDEX, 5, "stop");
        rdchk(MODE_CONTROL_INDEX, 0, "mode");
        $display("stop done");
        end_sim();
    end
endmodule // tick_timer_tb
bind tick_timer tick_timer_properties u_tick_timer_properties(.clock(clock),
    .reset_n(reset_n), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest),
    .tick_interrupt_request(tick_interrupt_request), .irq(irq));
